//--- ism_pkg.sv
// Constants, carriers and state layout for the interrupt source mapper
package ism_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_IRQ  = 32;
    localparam int NUM_ENT  = 34;
    localparam int ENT_W    = 6;
    localparam int PRIO_W   = 2;
    localparam int EXC_W    = 6;
    localparam int CAUSE_W  = 8;
    localparam int PIN_NUM  = 8;
    localparam int SPI_NUM  = 2;
    localparam int USART_NUM = 3;
    localparam int RT_CH    = 4;

    // ------------------------------------------------------------
    // Vector input line positions
    // ------------------------------------------------------------
    localparam int IRQ_SPI0    = 0;
    localparam int IRQ_USART0  = 3;
    localparam int IRQ_TWI     = 8;
    localparam int IRQ_STIMER  = 9;
    localparam int IRQ_RTIMER  = 10;
    localparam int IRQ_CMP     = 11;
    localparam int IRQ_WDOG    = 12;
    localparam int IRQ_BROWN   = 13;
    localparam int IRQ_FLASH   = 14;
    localparam int IRQ_WAKE    = 15;
    localparam int IRQ_PIN0    = 24;
    localparam logic [31:0] RSVD_MASK = 32'h00FF_00C4;

    // ------------------------------------------------------------
    // Exception numbers and arbiter entries
    // ------------------------------------------------------------
    localparam logic [EXC_W-1:0] EXC_NMI      = 6'h02;
    localparam logic [EXC_W-1:0] EXC_SVC      = 6'h0B;
    localparam logic [EXC_W-1:0] EXC_PENDABLE_SERVICE_EXCEPTION   = 6'h0E;
    localparam logic [EXC_W-1:0] EXC_IRQ_BASE = 6'h10;
    localparam logic [ENT_W-1:0] ENT_SVC      = 6'h20;
    localparam logic [ENT_W-1:0] ENT_PSV      = 6'h21;

    // ------------------------------------------------------------
    // Vector table base
    // ------------------------------------------------------------
    localparam logic [31:0] VTB_ALIGN_MASK = 32'hFFFF_FF80;
    localparam logic [31:0] VTB_RESET      = 32'h0000_0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CAUSE_W-1:0] flag;
        logic [CAUSE_W-1:0] en;
    } ism_gated_t;

    typedef struct packed {
        logic              valid;
        logic [EXC_W-1:0]  num;
        logic [PRIO_W-1:0] prio;
        logic [31:0]       vec;
    } ism_exc_t;

    typedef struct packed {
        logic               nmi_meta;
        logic               nmi_sync;
        logic               nmi_prev;
        logic               nmi_pend;
        logic               svc_pend;
        logic               psv_pend;
        logic [NUM_IRQ-1:0] pend;
        logic               active;
        logic [31:0]        vtb;
        logic [ENT_W-1:0]   rr;
        logic [ENT_W-1:0]   ent;
        ism_exc_t           exc;
    } ism_state_t;

    localparam ism_state_t ISM_STATE_RST = '{
        nmi_meta: 1'b0, nmi_sync: 1'b0, nmi_prev: 1'b0, nmi_pend: 1'b0,
        svc_pend: 1'b0, psv_pend: 1'b0, pend: 32'h0000_0000,
        active: 1'b0, vtb: VTB_RESET, rr: 6'h00, ent: 6'h00,
        exc: '{valid: 1'b0, num: 6'h00, prio: 2'h0, vec: 32'h0000_0000}};

endpackage : ism_pkg

//--- ism_prio_arb.sv
// Priority arbiter with rotating tie break among equal levels
`timescale 1ns/1ps
`default_nettype none
module ism_prio_arb
    import ism_pkg::*;
#(
    parameter int N  = NUM_ENT,
    parameter int IW = ENT_W,
    parameter int PW = PRIO_W
) (
    // Requests
    input  wire logic [N-1:0]         req,
    input  wire logic [N-1:0][PW-1:0] prio,
    input  wire logic [IW-1:0]        rr,
    // Grant
    output logic                      gnt_valid,
    output logic [IW-1:0]             gnt_idx,
    output logic [PW-1:0]             gnt_prio
);

    // ------------------------------------------------------------
    // Lowest level number wins; equal levels rotate from rr
    // ------------------------------------------------------------
    always_comb begin
        int j;
        logic found;
        j         = 0;
        found     = 1'b0;
        gnt_valid = 1'b0;
        gnt_prio  = '1;
        gnt_idx   = '0;
        for (int i = 0; i < N; i++) begin
            if (req[i] && (!gnt_valid || prio[i] < gnt_prio)) begin
                gnt_valid = 1'b1;
                gnt_prio  = prio[i];
            end
        end
        for (int k = 0; k < N; k++) begin
            j = int'(rr) + k;
            if (j >= N) begin
                j = j - N;
            end
            if (!found && req[j] && prio[j] == gnt_prio) begin
                found   = 1'b1;
                gnt_idx = IW'(j);
            end
        end
    end

endmodule : ism_prio_arb
`default_nettype wire

//--- ism_irq_mapper.sv
// Vectored interrupt controller with fixed peripheral line mapping
//
// Functional notes
// - Thirty-two vectored inputs, each with its own vector entry, plus system exceptions.
// - Four programmable levels; level numbers at or above the priority mask level are held off.
// - Supervisor call and pendable service exceptions raise interrupts from software.
// - A vector table base register relocates handler address fetches.
// - The programmed level orders interrupts; equal levels take turns in line order, starting after the last one taken.
// - Lines 0 and 1 carry the two synchronous serial interrupts, enable gated.
// - Lines 3 to 5 carry the three transceiver interrupts, enable gated.
// - Line 8 carries the two-wire bus interrupt, enable gated.
// - Line 11 carries the comparator edge flag.
// - Line 12 carries the watchdog warning flag.
// - Line 13 carries the brownout interrupt.
// - Line 15 carries the wake-up timer alarm flag.
// - Lines 24 to 28 carry pin interrupt channels 0 to 4.
// - Lines 29 to 31 carry pin interrupt channels 5 to 7.
`timescale 1ns/1ps
`default_nettype none
module ism_irq_mapper
    import ism_pkg::*;
(
    // Clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            reset,
    // Gated peripheral sources
    input  wire ism_gated_t [SPI_NUM-1:0]        spi_src,
    input  wire ism_gated_t [USART_NUM-1:0]      usart_src,
    input  wire ism_gated_t                      twi_src,
    input  wire ism_gated_t                      state_timer_event_flags,
    // Single flag sources
    input  wire logic [RT_CH-1:0]                rate_timer_channel_flag,
    input  wire logic                            comparator_edge_flag,
    input  wire logic                            watchdog_warning_flag,
    input  wire logic                            brownout_irq_level,
    input  wire logic                            flash_irq,
    input  wire logic                            wakeup_alarm_flag,
    input  wire logic [PIN_NUM-1:0]              pin_irq_status,
    // Controller configuration
    input  wire logic [NUM_IRQ-1:0]              irq_enable,
    input  wire logic [NUM_IRQ-1:0][PRIO_W-1:0]  irq_prio,
    input  wire logic [PRIO_W-1:0]               svc_prio,
    input  wire logic [PRIO_W-1:0]               psv_prio,
    input  wire logic                            prio_mask_en,
    input  wire logic [PRIO_W-1:0]               prio_mask_lvl,
    input  wire logic                            vtb_wr,
    input  wire logic [31:0]                     vtb_wdata,
    // Software exceptions and non-maskable pin
    input  wire logic                            supervisor_call_exception,
    input  wire logic                            pendable_service_set,
    input  wire logic                            pendable_service_clr,
    input  wire logic                            nmi_pin,
    // Core handshake
    input  wire logic                            exc_ack,
    input  wire logic                            exc_done,
    output ism_exc_t                             exc_req,
    output logic [NUM_IRQ-1:0]                   irq_pending,
    output logic                                 exc_active,
    output logic [31:0]                          vector_table_base_reg
);

    ism_state_t                      s_r;
    ism_state_t                      s_nxt;
    logic [NUM_IRQ-1:0]              line_v;
    logic [NUM_ENT-1:0]              req_v;
    logic [NUM_ENT-1:0][PRIO_W-1:0]  ent_prio;
    logic                            arb_valid;
    logic [ENT_W-1:0]                arb_idx;
    logic [PRIO_W-1:0]               arb_prio;
    logic                            ack_hit;
    logic                            better_wait;

    // ------------------------------------------------------------
    // Line mapping
    // ------------------------------------------------------------
    always_comb begin
        line_v = '0;
        for (int i = 0; i < SPI_NUM; i++) begin
            line_v[IRQ_SPI0 + i] = |(spi_src[i].flag & spi_src[i].en);
        end
        for (int i = 0; i < USART_NUM; i++) begin
            line_v[IRQ_USART0 + i] = |(usart_src[i].flag & usart_src[i].en);
        end
        line_v[IRQ_TWI]    = |(twi_src.flag & twi_src.en);
        line_v[IRQ_STIMER] = |(state_timer_event_flags.flag
                               & state_timer_event_flags.en);
        line_v[IRQ_RTIMER] = |rate_timer_channel_flag;
        line_v[IRQ_CMP]    = comparator_edge_flag;
        line_v[IRQ_WDOG]   = watchdog_warning_flag;
        line_v[IRQ_BROWN]  = brownout_irq_level;
        line_v[IRQ_FLASH]  = flash_irq;
        line_v[IRQ_WAKE]   = wakeup_alarm_flag;
        for (int i = 0; i < PIN_NUM; i++) begin
            line_v[IRQ_PIN0 + i] = pin_irq_status[i];
        end
        line_v = line_v & ~RSVD_MASK;
    end

    // ------------------------------------------------------------
    // Request vector and level masking
    // ------------------------------------------------------------
    always_comb begin
        req_v    = '0;
        ent_prio = '0;
        for (int i = 0; i < NUM_IRQ; i++) begin
            ent_prio[i] = irq_prio[i];
            req_v[i]    = s_r.pend[i] & irq_enable[i];
        end
        ent_prio[ENT_SVC] = svc_prio;
        ent_prio[ENT_PSV] = psv_prio;
        req_v[ENT_SVC]    = s_r.svc_pend;
        req_v[ENT_PSV]    = s_r.psv_pend;
        for (int i = 0; i < NUM_ENT; i++) begin
            if (prio_mask_en && ent_prio[i] >= prio_mask_lvl) begin
                req_v[i] = 1'b0;
            end
        end
    end

    ism_prio_arb #(
        .N  (NUM_ENT),
        .IW (ENT_W),
        .PW (PRIO_W)
    ) u_arb (
        .req       (req_v),
        .prio      (ent_prio),
        .rr        (s_r.rr),
        .gnt_valid (arb_valid),
        .gnt_idx   (arb_idx),
        .gnt_prio  (arb_prio)
    );

    assign ack_hit = s_r.exc.valid & exc_ack;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.nmi_meta = nmi_pin;
        s_nxt.nmi_sync = s_r.nmi_meta;
        s_nxt.nmi_prev = s_r.nmi_sync;
        if (vtb_wr) begin
            s_nxt.vtb = vtb_wdata & VTB_ALIGN_MASK;
        end
        // Clears first, so a same-cycle set always survives
        if (ack_hit) begin
            s_nxt.exc.valid = 1'b0;
            s_nxt.active    = 1'b1;
            if (s_r.exc.num == EXC_NMI) begin
                s_nxt.nmi_pend = 1'b0;
            end else begin
                s_nxt.rr = (s_r.ent == ENT_PSV) ? '0 : s_r.ent + 6'h01;
                if (s_r.ent == ENT_SVC) begin
                    s_nxt.svc_pend = 1'b0;
                end else if (s_r.ent == ENT_PSV) begin
                    s_nxt.psv_pend = 1'b0;
                end else begin
                    s_nxt.pend[s_r.ent[4:0]] = 1'b0;
                end
            end
        end else if (exc_done) begin
            s_nxt.active = 1'b0;
        end
        if (pendable_service_clr) begin
            s_nxt.psv_pend = 1'b0;
        end
        s_nxt.pend = s_nxt.pend | line_v;
        if (supervisor_call_exception) begin
            s_nxt.svc_pend = 1'b1;
        end
        if (pendable_service_set) begin
            s_nxt.psv_pend = 1'b1;
        end
        if (s_r.nmi_sync && !s_r.nmi_prev) begin
            s_nxt.nmi_pend = 1'b1;
        end
        // Present the next exception to the core
        if (!s_r.exc.valid) begin
            if (s_r.nmi_pend) begin
                s_nxt.exc.valid = 1'b1;
                s_nxt.exc.num   = EXC_NMI;
                s_nxt.exc.prio  = '0;
            end else if (!s_r.active && arb_valid) begin
                s_nxt.exc.valid = 1'b1;
                s_nxt.exc.prio  = arb_prio;
                s_nxt.ent       = arb_idx;
                if (arb_idx == ENT_SVC) begin
                    s_nxt.exc.num = EXC_SVC;
                end else if (arb_idx == ENT_PSV) begin
                    s_nxt.exc.num = EXC_PENDABLE_SERVICE_EXCEPTION;
                end else begin
                    s_nxt.exc.num = EXC_IRQ_BASE + arb_idx;
                end
            end
            s_nxt.exc.vec = s_nxt.vtb + {24'h00_0000, s_nxt.exc.num, 2'b00};
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_r <= ISM_STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign exc_req               = s_r.exc;
    assign irq_pending           = s_r.pend;
    assign exc_active            = s_r.active;
    assign vector_table_base_reg = s_r.vtb;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    always_comb begin
        better_wait = 1'b0;
        for (int i = 0; i < NUM_ENT; i++) begin
            if (req_v[i] && ent_prio[i] < arb_prio) begin
                better_wait = 1'b1;
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    AST_RESERVED_QUIET: assert property ((s_r.pend & RSVD_MASK) == '0)
        else $error("reserved line pended");
    AST_LINE_LATCHED: assert property (1'b1 |=> ((s_r.pend & $past(line_v))
        == $past(line_v)))
        else $error("active line not pending");
    AST_SPI1_LINE: assert property (|(spi_src[1].flag & spi_src[1].en)
        |=> s_r.pend[1])
        else $error("serial 1 not on line 1");
    AST_USART2_LINE: assert property (|(usart_src[2].flag & usart_src[2].en)
        |=> s_r.pend[5])
        else $error("transceiver 2 not on line 5");
    AST_TWI_LINE: assert property (|(twi_src.flag & twi_src.en) |=> s_r.pend[8])
        else $error("two-wire not on line 8");
    AST_RTIMER_LINE: assert property (rate_timer_channel_flag[3] |=> s_r.pend[10])
        else $error("rate timer not on line 10");
    AST_CMP_LINE: assert property (comparator_edge_flag |=> s_r.pend[11])
        else $error("comparator not on line 11");
    AST_WDOG_LINE: assert property (watchdog_warning_flag |=> s_r.pend[12])
        else $error("watchdog not on line 12");
    AST_BROWN_LINE: assert property (brownout_irq_level |=> s_r.pend[13])
        else $error("brownout not on line 13");
    AST_WAKE_LINE: assert property (wakeup_alarm_flag |=> s_r.pend[15])
        else $error("wake-up not on line 15");
    AST_PIN0_LINE: assert property (pin_irq_status[0] |=> s_r.pend[24])
        else $error("pin 0 not on line 24");
    AST_PIN7_LINE: assert property (pin_irq_status[7] |=> s_r.pend[31])
        else $error("pin 7 not on line 31");
    AST_MASK_HOLDS: assert property ($rose(s_r.exc.valid) && s_r.exc.num != EXC_NMI
        && $past(prio_mask_en) |-> s_r.exc.prio < $past(prio_mask_lvl))
        else $error("masked level presented");
    AST_BEST_LEVEL: assert property (arb_valid |-> !better_wait && req_v[arb_idx])
        else $error("better level passed over");
    AST_SVC_PENDS: assert property (supervisor_call_exception |=> s_r.svc_pend)
        else $error("supervisor call lost");
    AST_VECTOR_ADDR: assert property (s_r.exc.valid |-> s_r.exc.vec
        == s_r.vtb + {24'h00_0000, s_r.exc.num, 2'b00})
        else $error("vector address wrong");
    AST_ACK_TAKES: assert property (ack_hit |=> !s_r.exc.valid ##0 s_r.active)
        else $error("ack not taken");

    COV_NMI_TAKEN: cover property (s_r.exc.valid && s_r.exc.num == EXC_NMI && exc_ack);
    COV_SVC_TAKEN: cover property (s_r.exc.valid && s_r.exc.num == EXC_SVC && exc_ack);
    COV_PIN_IRQ: cover property (s_r.exc.valid && s_r.exc.num == 6'h2B);
    COV_MASKED: cover property (prio_mask_en && |s_r.pend && !arb_valid);

endmodule : ism_irq_mapper
`default_nettype wire

//--- ism_core_model.sv
// Core model that takes presented exceptions and runs a short handler
`timescale 1ns/1ps
`default_nettype none
module ism_core_model
    import ism_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Controller handshake
    input  wire ism_exc_t    exc_req,
    input  wire logic        exc_active,
    output logic             exc_ack,
    output logic             exc_done,
    // Pacing and log of taken exceptions
    input  wire logic [3:0]  ack_delay,
    output logic [EXC_W-1:0] taken_num,
    output logic [31:0]      taken_vec,
    output logic [15:0]      taken_cnt
);
    int   wait_cnt;
    int   run_cnt;
    logic go_ack;
    logic go_done;

    initial begin
        exc_ack   = 1'b0;
        exc_done  = 1'b0;
        taken_num = '0;
        taken_vec = '0;
        taken_cnt = '0;
        wait_cnt  = 0;
        run_cnt   = 0;
        forever begin
            @(negedge core_clk);
            go_ack  = 1'b0;
            go_done = 1'b0;
            if (reset) begin
                wait_cnt = 0;
                run_cnt  = 0;
            end else if (exc_req.valid && !exc_ack) begin
                // Slow acknowledge leaves the presentation standing
                if (wait_cnt >= int'(ack_delay)) begin
                    go_ack    = 1'b1;
                    taken_num <= exc_req.num;
                    taken_vec <= exc_req.vec;
                    taken_cnt <= taken_cnt + 16'h0001;
                    wait_cnt  = 0;
                end else begin
                    wait_cnt++;
                end
            end else if (exc_active && !exc_ack) begin
                if (run_cnt >= 3) begin
                    go_done  = 1'b1;
                    run_cnt  = 0;
                end else begin
                    run_cnt++;
                end
            end
            exc_ack  <= go_ack;
            exc_done <= go_done;
        end
    end
endmodule : ism_core_model
`default_nettype wire

//--- ism_irq_mapper_bench.sv
// Self-checking bench for the interrupt source mapper
`timescale 1ns/1ps
`default_nettype none
module ism_irq_mapper_bench
    import ism_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                           core_clk;
    logic                           reset;
    ism_gated_t [SPI_NUM-1:0]       spi_src;
    ism_gated_t [USART_NUM-1:0]     usart_src;
    ism_gated_t                     twi_src;
    ism_gated_t                     state_timer_event_flags;
    logic [RT_CH-1:0]               rate_timer_channel_flag;
    logic                           comparator_edge_flag;
    logic                           watchdog_warning_flag;
    logic                           brownout_irq_level;
    logic                           flash_irq;
    logic                           wakeup_alarm_flag;
    logic [PIN_NUM-1:0]             pin_irq_status;
    logic [NUM_IRQ-1:0]             irq_enable;
    logic [NUM_IRQ-1:0][PRIO_W-1:0] irq_prio;
    logic [PRIO_W-1:0]              svc_prio;
    logic [PRIO_W-1:0]              psv_prio;
    logic                           prio_mask_en;
    logic [PRIO_W-1:0]              prio_mask_lvl;
    logic                           vtb_wr;
    logic [31:0]                    vtb_wdata;
    logic                           supervisor_call_exception;
    logic                           pendable_service_set;
    logic                           pendable_service_clr;
    logic                           nmi_pin;
    logic                           exc_ack;
    logic                           exc_done;
    ism_exc_t                       exc_req;
    logic [NUM_IRQ-1:0]             irq_pending;
    logic                           exc_active;
    logic [31:0]                    vector_table_base_reg;
    logic [3:0]                     ack_delay;
    logic [EXC_W-1:0]               taken_num;
    logic [31:0]                    taken_vec;
    logic [15:0]                    taken_cnt;
    logic [15:0]                    exp_cnt;
    logic [31:0]                    base_exp;
    int                             err_total;
    int                             samples_checked;
    int                             cycles = 0;

    ism_irq_mapper ism_irq_mapper_i (.*);
    ism_core_model ism_core_model_i (.*);

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask : step

    task automatic set_line(input int n, input logic v);
        case (n)
            0, 1:    spi_src[n].flag[n+1] = v;
            3, 4, 5: usart_src[n-3].flag[n] = v;
            8:       twi_src.flag[7] = v;
            9:       state_timer_event_flags.flag[0] = v;
            10:      rate_timer_channel_flag[3] = v;
            11:      comparator_edge_flag = v;
            12:      watchdog_warning_flag = v;
            13:      brownout_irq_level = v;
            14:      flash_irq = v;
            15:      wakeup_alarm_flag = v;
            default: pin_irq_status[n-24] = v;
        endcase
    endtask : set_line

    task automatic set_en(input logic [7:0] v);
        spi_src[0].en = v;
        spi_src[1].en = v;
        usart_src[0].en = v;
        usart_src[1].en = v;
        usart_src[2].en = v;
        twi_src.en = v;
        state_timer_event_flags.en = v;
    endtask : set_en

    // Wait for the core model to take one exception, then for its handler to end
    task automatic take(input logic [EXC_W-1:0] num, input string what);
        int i;
        i = 0;
        while (taken_cnt === exp_cnt && i < 60) begin
            step(1);
            i++;
        end
        exp_cnt = exp_cnt + 16'h0001;
        chk({what, " count"}, {16'h0000, exp_cnt}, {16'h0000, taken_cnt});
        chk({what, " number"}, {26'h0, num}, {26'h0, taken_num});
        chk({what, " vector"}, base_exp + {24'h0, num, 2'b00}, taken_vec);
        step(2);
        i = 0;
        while (exc_active !== 1'b0 && i < 20) begin
            step(1);
            i++;
        end
        chk({what, " handler end"}, 32'h0, {31'h0, exc_active});
    endtask : take

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic soft_exc();
        vtb_wr = 1'b1;
        vtb_wdata = 32'h0000_12FF;
        step(1);
        vtb_wr = 1'b0;
        chk("vector base", 32'h0000_1280, vector_table_base_reg);
        base_exp = 32'h0000_1280;
        supervisor_call_exception = 1'b1;
        step(1);
        supervisor_call_exception = 1'b0;
        take(EXC_SVC, "svc");
        pendable_service_set = 1'b1;
        step(1);
        pendable_service_set = 1'b0;
        take(EXC_PENDABLE_SERVICE_EXCEPTION, "pendable_service_exception");
        prio_mask_en = 1'b1;
        prio_mask_lvl = 2'h0;
        pendable_service_set = 1'b1;
        nmi_pin = 1'b1;
        step(1);
        pendable_service_set = 1'b0;
        take(EXC_NMI, "nmi under mask");
        pendable_service_clr = 1'b1;
        step(1);
        pendable_service_clr = 1'b0;
        prio_mask_en = 1'b0;
        nmi_pin = 1'b0;
        step(8);
        chk("pendable_service_exception withdrawn", {16'h0000, exp_cnt}, {16'h0000, taken_cnt});
    endtask : soft_exc

    task automatic gate_off();
        int gl[7] = '{0, 1, 3, 4, 5, 8, 9};
        set_en(8'h00);
        for (int k = 0; k < 7; k++) set_line(gl[k], 1'b1);
        step(3);
        chk("gated causes", 32'h0, irq_pending);
        for (int k = 0; k < 7; k++) set_line(gl[k], 1'b0);
        set_en(8'hFF);
    endtask : gate_off

    task automatic line_map();
        for (int n = 0; n < NUM_IRQ; n++) begin
            if (RSVD_MASK[n] == 1'b0) begin
                ack_delay = n[3:0];
                set_line(n, 1'b1);
                step(1);
                set_line(n, 1'b0);
                chk("line pending", 32'h1 << n, irq_pending);
                take(EXC_IRQ_BASE + n[5:0], "line");
                chk("pending left", 32'h0, irq_pending);
            end
        end
        ack_delay = 4'h1;
    endtask : line_map

    task automatic prio_order();
        irq_enable = '0;
        irq_prio[3] = 2'h2;
        set_line(3, 1'b1);
        set_line(24, 1'b1);
        step(1);
        set_line(3, 1'b0);
        set_line(24, 1'b0);
        step(4);
        chk("both pending", 32'h0100_0008, irq_pending);
        chk("none while disabled", {16'h0000, exp_cnt}, {16'h0000, taken_cnt});
        irq_enable = '1;
        take(6'h28, "level 0 at line 24");
        step(1);
        chk("level at line 3", 32'h2, {30'h0, exc_req.prio});
        take(6'h13, "level 2 at line 3");
        irq_prio[3] = 2'h0;
        irq_prio[11] = 2'h1;
        prio_mask_en = 1'b1;
        prio_mask_lvl = 2'h1;
        set_line(11, 1'b1);
        step(1);
        set_line(11, 1'b0);
        step(8);
        chk("masked level", {16'h0000, exp_cnt}, {16'h0000, taken_cnt});
        prio_mask_lvl = 2'h2;
        take(6'h1B, "unmasked level");
        prio_mask_en = 1'b0;
        // Equal levels after line 11 was taken: line 24 comes before line 3
        set_line(3, 1'b1);
        set_line(24, 1'b1);
        step(1);
        set_line(3, 1'b0);
        set_line(24, 1'b0);
        take(6'h28, "equal level rotation");
        take(6'h13, "equal level next");
    endtask : prio_order

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        err_total = 0;
        samples_checked = 0;
        exp_cnt = '0;
        base_exp = '0;
        reset = 1'b1;
        spi_src = '0;
        usart_src = '0;
        twi_src = '0;
        state_timer_event_flags = '0;
        set_en(8'hFF);
        rate_timer_channel_flag = '0;
        comparator_edge_flag = 1'b0;
        watchdog_warning_flag = 1'b0;
        brownout_irq_level = 1'b0;
        flash_irq = 1'b0;
        wakeup_alarm_flag = 1'b0;
        pin_irq_status = '0;
        irq_enable = '1;
        irq_prio = '0;
        svc_prio = 2'h0;
        psv_prio = 2'h1;
        prio_mask_en = 1'b0;
        prio_mask_lvl = 2'h0;
        {vtb_wr, vtb_wdata, nmi_pin} = '0;
        {supervisor_call_exception, pendable_service_set, pendable_service_clr} = '0;
        ack_delay = 4'h0;
        step(10);
        reset = 1'b0;
        step(1);
        chk("pending after reset", 32'h0, irq_pending);
        chk("base after reset", VTB_RESET, vector_table_base_reg);
        chk("valid after reset", 32'h0, {31'h0, exc_req.valid});
        soft_exc();
        gate_off();
        line_map();
        prio_order();
        print_verdict();
    end

    initial begin
        forever begin
            @(posedge core_clk);
            cycles++;
            if (cycles == 5000) begin
                err_total++;
                print_verdict();
            end
        end
    end
endmodule : ism_irq_mapper_bench
`default_nettype wire
